// file: hdl/dci_cmd_issue.sv
`timescale 1ns/10ps
`include "dci_defs.svh"
module dci_cmd_issue
	import dci_pkg::*;
(
	input  wire logic        clk_sys_i,          // system clock
	input  wire logic        clk_mem_i,          // memory link clock
	input  wire logic        nrst_i,             // async reset, low
	input  wire logic        req_valid_i,        // access request
	output logic             req_ready_o,        // request taken
	input  wire logic        req_write_i,        // 1 write, 0 read
	input  wire logic        req_autopre_i,      // read autoprecharge
	input  wire dci_bank_t   req_bank_i,         // bank
	input  wire dci_addr_t   req_row_i,          // row
	input  wire logic [12:0] req_col_i,          // start column
	output logic             req_done_o,         // command sent pulse
	input  wire dci_rate_t   refresh_rate_i,     // refresh interval
	input  wire logic [12:0] mode_reg_i,         // mode register value
	input  wire logic [12:0] ext_mode_reg_i,     // ext mode value
	input  wire logic        self_refresh_i,     // self-refresh request
	input  wire logic        power_down_i,       // power-down request
	output logic             init_done_o,        // init finished
	output logic             low_power_o,        // in low power
	output logic             chip_enable_n_o,    // chip enable, low
	output logic             mem_clock_enable_o, // memory cke
	output logic             row_strobe_n_o,     // row strobe, low
	output logic             column_strobe_n_o,  // column strobe, low
	output logic             write_enable_n_o,   // write enable, low
	output dci_bank_t        bank_addr_out_o,    // bank pins
	output dci_addr_t        mem_addr_out_o      // address pins
);
	// ------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------
	localparam dci_cnt_t RCD_CYC = dci_cnt_t'(`DCI_CYC(`DCI_T_RCD_NS));
	localparam dci_cnt_t RP_CYC  = dci_cnt_t'(`DCI_CYC(`DCI_T_RP_NS));
	localparam dci_cnt_t MRD_CYC = dci_cnt_t'(`DCI_CYC(`DCI_T_MRD_NS));
	localparam dci_cnt_t RFC_CYC = dci_cnt_t'(`DCI_CYC(`DCI_T_RFC_NS));
	localparam dci_cnt_t XSR_CYC = dci_cnt_t'(`DCI_CYC(`DCI_T_XSR_NS));

	typedef struct packed {
		dci_state_t        st;
		dci_state_t        ret;
		dci_cnt_t          cnt;
		logic              req_tgl;
		dci_pins_t         word;
		dci_cmd_t          last_cmd;
		dci_rate_t         ref_cnt;
		logic              ref_pend;
		logic [7:0]        open_vld;
		logic [7:0][13:0]  open_row;
		dci_bank_t         q_bank;
		dci_addr_t         q_row;
		logic [12:0]       q_col;
		logic              q_wr;
		logic              q_ap;
		logic              lp_self;
		logic              init_done;
		logic              done;
	} dci_main_t;

	dci_main_t  r_reg;
	dci_main_t  r_next;
	dci_xfer_if xf ();
	dci_pins_t  pins;
	logic       ack_s;
	logic       busy;
	logic       hit;
	logic       tick;
	logic       ref_clr;
	logic       go;
	dci_cmd_t   go_cmd;
	dci_bank_t  go_ba;
	dci_addr_t  go_addr;
	dci_state_t go_ret;
	dci_cnt_t   go_wait;
	dci_pins_t  go_word;

	// ------------------------------------------------------------
	// command encoding
	// ------------------------------------------------------------
	function automatic dci_pins_t enc(dci_cmd_t c, dci_bank_t ba,
			dci_addr_t ad);
		dci_pins_t p;
		p = '{1'b1, 1'b1, 1'b1, 1'b1, ba, ad};
		case (c)
		cmd_activate: begin
			p.row_strobe_n = 1'b0;
		end
		cmd_precharge_all: begin
			p.row_strobe_n = 1'b0;
			p.write_enable_n = 1'b0;
			p.mem_addr_out[`DCI_A10] = 1'b1;
		end
		cmd_precharge_one: begin
			p.row_strobe_n = 1'b0;
			p.write_enable_n = 1'b0;
			p.mem_addr_out[`DCI_A10] = 1'b0;
		end
		cmd_mode_write: begin
			p.row_strobe_n = 1'b0;
			p.column_strobe_n = 1'b0;
			p.write_enable_n = 1'b0;
		end
		cmd_read: begin
			p.column_strobe_n = 1'b0;
		end
		cmd_write: begin
			p.column_strobe_n = 1'b0;
			p.write_enable_n = 1'b0;
			p.mem_addr_out[`DCI_A10] = 1'b0;
		end
		cmd_auto_refresh: begin
			p.row_strobe_n = 1'b0;
			p.column_strobe_n = 1'b0;
		end
		cmd_self_refresh: begin
			p.mem_clock_enable = 1'b0;
			p.row_strobe_n = 1'b0;
			p.column_strobe_n = 1'b0;
		end
		cmd_power_down: begin
			p.mem_clock_enable = 1'b0;
		end
		default: begin
			p.mem_clock_enable = 1'b1; // nop, also low-power exit
		end
		endcase
		return p;
	endfunction

	// ------------------------------------------------------------
	// crossing to the memory clock
	// ------------------------------------------------------------
	dci_sync #(.W(1)) u_ack_sync (
		.clk_i  (clk_sys_i),
		.nrst_i (nrst_i),
		.d_i    (xf.ack_tgl),
		.q_o    (ack_s)
	);

	dci_link u_link (
		.clk_mem_i (clk_mem_i),
		.nrst_i    (nrst_i),
		.xf        (xf.lnk),
		.pins_o    (pins)
	);

	assign xf.req_tgl = r_reg.req_tgl;
	assign xf.word = r_reg.word;
	// a word in flight until the link echoes its toggle
	assign busy = r_reg.req_tgl ^ ack_s;
	assign hit = r_reg.open_vld[req_bank_i]
		&& (r_reg.open_row[req_bank_i] == req_row_i);
	assign tick = (r_reg.ref_cnt <= dci_rate_t'(1));
	assign go_word = enc(go_cmd, go_ba, go_addr);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		go = 1'b0;
		go_cmd = cmd_nop;
		go_ba = r_reg.q_bank;
		go_addr = '0;
		go_ret = ST_IDLE;
		go_wait = '0;
		ref_clr = 1'b0;
		case (r_reg.st)
		ST_BOOT_PRE: begin
			go = 1'b1;
			go_cmd = cmd_precharge_all;
			go_ret = ST_INIT_EMR;
			go_wait = RP_CYC;
			// memory ignores a command in the cycle cke comes up,
			// so the first word after reset is a nop raising it
			if (!r_reg.word.mem_clock_enable) begin
				go_cmd = cmd_nop;
				go_ret = ST_BOOT_PRE;
				go_wait = '0;
			end
		end
		ST_INIT_EMR: begin
			go = 1'b1;
			go_cmd = cmd_mode_write;
			go_ba = `DCI_BA_EXTMODE;
			go_addr = {1'b0, ext_mode_reg_i};
			go_ret = ST_INIT_MR;
			go_wait = MRD_CYC;
		end
		ST_INIT_MR: begin
			go = 1'b1;
			go_cmd = cmd_mode_write;
			go_ba = `DCI_BA_MODE;
			go_addr = {1'b0, mode_reg_i};
			go_ret = ST_INIT_PRE;
			go_wait = MRD_CYC;
		end
		ST_INIT_PRE: begin
			go = 1'b1;
			go_cmd = cmd_precharge_all;
			go_wait = RP_CYC;
			r_next.init_done = 1'b1;
		end
		ST_IDLE: begin
			// refresh first, so a pending refresh goes out before low-power entry
			if (r_reg.ref_pend) begin
				r_next.st = ST_REF_PRE;
			end else if (self_refresh_i || power_down_i) begin
				r_next.lp_self = self_refresh_i;
				r_next.st = ST_LP_PRE;
			end else if (req_valid_i) begin
				r_next.q_bank = req_bank_i;
				r_next.q_row = req_row_i;
				r_next.q_col = req_col_i;
				r_next.q_wr = req_write_i;
				r_next.q_ap = req_autopre_i;
				if (hit) begin
					r_next.st = ST_RW;
				end else if (r_reg.open_vld[req_bank_i]) begin
					r_next.st = ST_MISS;
				end else begin
					r_next.st = ST_ACT;
				end
			end
		end
		ST_MISS: begin
			go = 1'b1;
			go_cmd = cmd_precharge_one;
			go_ret = ST_ACT;
			go_wait = RP_CYC;
			r_next.open_vld[r_reg.q_bank] = 1'b0;
		end
		ST_ACT: begin
			go = 1'b1;
			go_cmd = cmd_activate;
			go_addr = r_reg.q_row;
			go_ret = ST_RW;
			go_wait = RCD_CYC;
			r_next.open_vld[r_reg.q_bank] = 1'b1;
			r_next.open_row[r_reg.q_bank] = r_reg.q_row;
		end
		ST_RW: begin
			go = 1'b1;
			go_cmd = r_reg.q_wr ? cmd_write : cmd_read;
			go_addr = {1'b0, r_reg.q_col};
			go_addr[`DCI_A10] = r_reg.q_ap && !r_reg.q_wr;
			r_next.done = 1'b1;
			if (r_reg.q_ap && !r_reg.q_wr) begin
				r_next.open_vld[r_reg.q_bank] = 1'b0;
			end
		end
		ST_REF_PRE: begin
			go = 1'b1;
			go_cmd = cmd_precharge_all;
			go_ret = ST_REF;
			go_wait = RP_CYC;
			r_next.open_vld = '0;
		end
		ST_REF: begin
			go = 1'b1;
			go_cmd = cmd_auto_refresh;
			go_wait = RFC_CYC;
			ref_clr = 1'b1;
			r_next.open_vld = '0;
		end
		ST_LP_PRE: begin
			go = 1'b1;
			go_cmd = cmd_precharge_all;
			go_ret = ST_LP_ENTER;
			go_wait = RP_CYC;
			r_next.open_vld = '0;
		end
		ST_LP_ENTER: begin
			go = 1'b1;
			go_cmd = r_reg.lp_self ? cmd_self_refresh : cmd_power_down;
			go_ret = ST_LP_HOLD;
		end
		ST_LP_HOLD: begin
			if (r_reg.lp_self ? !self_refresh_i : !power_down_i) begin
				r_next.st = ST_LP_EXIT;
			end
		end
		ST_LP_EXIT: begin
			go = 1'b1;
			go_cmd = cmd_nop;
			go_wait = XSR_CYC;
		end
		default: begin
			// wait for the link echo, then the timing gap
			if (!busy) begin
				if (r_reg.cnt == '0) begin
					r_next.st = r_reg.ret;
				end else begin
					r_next.cnt = r_reg.cnt - dci_cnt_t'(1);
				end
			end
		end
		endcase
		// every issuing state is entered only with the link idle
		if (go) begin
			r_next.word = go_word;
			r_next.req_tgl = ~r_reg.req_tgl;
			r_next.last_cmd = go_cmd;
			r_next.st = ST_WAIT;
			r_next.ret = go_ret;
			r_next.cnt = go_wait;
		end
		// pacing has no enable at all
		r_next.ref_cnt = tick ? refresh_rate_i
			: r_reg.ref_cnt - dci_rate_t'(1);
		// a tick in the clearing cycle wins
		r_next.ref_pend = (r_reg.ref_pend && !ref_clr) || tick;
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_reg <= '0;
			r_reg.st <= ST_BOOT_PRE;
			r_reg.ret <= ST_IDLE;
			r_reg.word <= `DCI_PINS_RST;
			r_reg.last_cmd <= cmd_nop;
			r_reg.ref_cnt <= `DCI_REF_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign req_ready_o = (r_reg.st == ST_IDLE) && !r_reg.ref_pend
		&& !self_refresh_i && !power_down_i;
	assign req_done_o = r_reg.done;
	assign init_done_o = r_reg.init_done;
	assign low_power_o = (r_reg.st == ST_LP_HOLD);
	assign chip_enable_n_o = 1'b0;
	assign mem_clock_enable_o = pins.mem_clock_enable;
	assign row_strobe_n_o = pins.row_strobe_n;
	assign column_strobe_n_o = pins.column_strobe_n;
	assign write_enable_n_o = pins.write_enable_n;
	assign bank_addr_out_o = pins.bank_addr_out;
	assign mem_addr_out_o = pins.mem_addr_out;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	dci_cnt_t since_act;

	// cycles since last activate, saturating
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			since_act <= `DCI_SINCE_RST;
		end else if (go && go_cmd == cmd_activate) begin
			since_act <= '0;
		end else if (since_act != `DCI_SINCE_RST) begin
			since_act <= since_act + dci_cnt_t'(1);
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	act_encode_a: assert property (go && go_cmd == cmd_activate |->
		!go_word.row_strobe_n && go_word.column_strobe_n
		&& go_word.write_enable_n && go_word.mem_addr_out == r_reg.q_row
		##1 r_reg.open_vld[r_reg.q_bank])
		else $error("activate encoding wrong");
	prea_a10_a: assert property (go && go_cmd == cmd_precharge_all |->
		!go_word.row_strobe_n && !go_word.write_enable_n
		&& go_word.mem_addr_out[`DCI_A10])
		else $error("precharge-all encoding wrong");
	pre1_a10_a: assert property (go && go_cmd == cmd_precharge_one |->
		!go_word.mem_addr_out[`DCI_A10]
		&& go_word.bank_addr_out == r_reg.q_bank)
		else $error("single precharge encoding wrong");
	mode_init_a: assert property (go && go_cmd == cmd_mode_write |->
		!r_reg.init_done && r_reg.open_vld == '0
		&& !go_word.column_strobe_n)
		else $error("mode write outside init");
	ref_after_pre_a: assert property (go && go_cmd == cmd_auto_refresh |->
		r_reg.last_cmd == cmd_precharge_all
		&& r_reg.open_vld == '0)
		else $error("refresh without precharge-all");
	rcd_gap_a: assert property (go && (go_cmd == cmd_read
		|| go_cmd == cmd_write) |-> since_act >= RCD_CYC)
		else $error("read or write too soon after activate");
	ref_pages_a: assert property (go && go_cmd == cmd_auto_refresh |=>
		r_reg.open_vld == '0 [*2])
		else $error("page kept across refresh");
	ref_pace_a: assert property (tick |=> r_reg.ref_pend
		&& r_reg.ref_cnt == $past(refresh_rate_i))
		else $error("refresh tick lost");
	rw_a10_a: assert property (go && (go_cmd == cmd_read
		|| go_cmd == cmd_write) |-> go_word.mem_addr_out[`DCI_A10]
		== (r_reg.q_ap && !r_reg.q_wr))
		else $error("column address bit 10 wrong");
	sr_entry_a: assert property (go && go_cmd == cmd_self_refresh |->
		!go_word.mem_clock_enable && !go_word.column_strobe_n
		&& go_word.write_enable_n)
		else $error("self-refresh entry encoding wrong");
	ce_low_a: assert property (!chip_enable_n_o)
		else $error("chip enable went high");

	cover property (go && go_cmd == cmd_auto_refresh);
	cover property (go && go_cmd == cmd_activate ##[1:200]
		go && go_cmd == cmd_read);
	cover property (r_reg.st == ST_LP_HOLD && r_reg.lp_self);
	cover property (req_valid_i && req_ready_o && hit);
endmodule // dci_cmd_issue

// file: hdl/dci_defs.svh
`ifndef DCI_DEFS_SVH
`define DCI_DEFS_SVH

// ----------------------------------------------------------------
// clock rate and widths
// ----------------------------------------------------------------
`define DCI_CLK_MHZ    10
`define DCI_CNT_W      8
`define DCI_RATE_W     13
`define DCI_ROW_W      14
`define DCI_BANK_W     3
`define DCI_A10        10

// ----------------------------------------------------------------
// memory timing in ns, and derived cycle counts
// ----------------------------------------------------------------
`define DCI_T_RCD_NS   15
`define DCI_T_RP_NS    15
`define DCI_T_MRD_NS   20
`define DCI_T_RFC_NS   128
`define DCI_T_XSR_NS   200
// least times: round up, never below one cycle
`define DCI_CYC_RAW(ns) (((ns) * `DCI_CLK_MHZ + 999) / 1000)
`define DCI_CYC(ns) ((`DCI_CYC_RAW(ns) < 1) ? 1 : `DCI_CYC_RAW(ns))

// ----------------------------------------------------------------
// mode register selects and reset values
// ----------------------------------------------------------------
`define DCI_BA_MODE    3'h0
`define DCI_BA_EXTMODE 3'h1
`define DCI_PINS_RST   21'h0e_0000
`define DCI_REF_RST    13'h0000
`define DCI_SINCE_RST  8'hff

`endif

// file: hdl/dci_link.sv
`timescale 1ns/10ps
`include "dci_defs.svh"
module dci_link
	import dci_pkg::*;
(
	input  wire logic clk_mem_i, // memory clock
	input  wire logic nrst_i,    // async reset, active low
	dci_xfer_if.lnk   xf,        // command crossing
	output dci_pins_t pins_o     // registered pin bundle
);
	typedef struct packed {
		dci_pins_t pins;
		logic      last;
		logic      ack;
	} dci_link_t;

	dci_link_t r_reg;
	dci_link_t r_next;
	logic      req_s;

	dci_sync #(.W(1)) u_req_sync (
		.clk_i  (clk_mem_i),
		.nrst_i (nrst_i),
		.d_i    (xf.req_tgl),
		.q_o    (req_s)
	);

	// a new toggle means the word has been stable for two edges;
	// the command stands one memory cycle, then a nop keeps cke
	always_comb begin
		r_next = r_reg;
		r_next.pins.row_strobe_n = 1'b1;
		r_next.pins.column_strobe_n = 1'b1;
		r_next.pins.write_enable_n = 1'b1;
		if (req_s != r_reg.last) begin
			r_next.pins = xf.word;
			r_next.last = req_s;
			r_next.ack = req_s;
		end
	end

	always_ff @(posedge clk_mem_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_reg <= '{pins: `DCI_PINS_RST, last: 1'b0, ack: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign pins_o = r_reg.pins;
	assign xf.ack_tgl = r_reg.ack;
endmodule // dci_link

// file: hdl/dci_pkg.sv
package dci_pkg;
`include "dci_defs.svh"

	typedef logic [`DCI_CNT_W-1:0]  dci_cnt_t;
	typedef logic [`DCI_RATE_W-1:0] dci_rate_t;
	typedef logic [`DCI_ROW_W-1:0]  dci_addr_t;
	typedef logic [`DCI_BANK_W-1:0] dci_bank_t;

	typedef enum logic [3:0] {
		cmd_nop,
		cmd_activate,
		cmd_precharge_all,
		cmd_precharge_one,
		cmd_mode_write,
		cmd_read,
		cmd_write,
		cmd_auto_refresh,
		cmd_self_refresh,
		cmd_power_down
	} dci_cmd_t;

	typedef enum logic [3:0] {
		ST_BOOT_PRE, ST_INIT_EMR, ST_INIT_MR, ST_INIT_PRE, ST_IDLE,
		ST_MISS, ST_ACT, ST_RW, ST_REF_PRE, ST_REF, ST_LP_PRE,
		ST_LP_ENTER, ST_LP_HOLD, ST_LP_EXIT, ST_WAIT
	} dci_state_t;

	// pin bundle, one memory command
	typedef struct packed {
		logic      mem_clock_enable;
		logic      row_strobe_n;
		logic      column_strobe_n;
		logic      write_enable_n;
		dci_bank_t bank_addr_out;
		dci_addr_t mem_addr_out;
	} dci_pins_t;
endpackage

// file: hdl/dci_sync.sv
`timescale 1ns/10ps
module dci_sync
	import dci_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk_i,   // destination clock
	input  wire logic         nrst_i,  // async reset, active low
	input  wire logic [W-1:0] d_i,     // foreign-domain level
	output logic      [W-1:0] q_o      // synchronised level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dci_sync_st_t;

	dci_sync_st_t r_reg;
	dci_sync_st_t r_next;

	// first stage feeds only the second
	always_comb begin
		r_next.s1 = d_i;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign q_o = r_reg.s2;
endmodule // dci_sync

// file: hdl/dci_xfer_if.sv
`timescale 1ns/10ps
// command word crossing from system clock to memory clock
interface dci_xfer_if;
	import dci_pkg::*;
	logic      req_tgl;
	logic      ack_tgl;
	dci_pins_t word;

	modport sys (output req_tgl, output word, input ack_tgl);
	modport lnk (input req_tgl, input word, output ack_tgl);
endinterface

// file: verif/dci_sdram_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// memory device model: decodes the pins and tracks open banks
// ----------------------------------------------------------------
module dci_sdram_model
	import dci_pkg::*;
(
	input  wire logic      clk_mem_i,   // memory clock
	input  wire logic      nrst_i,      // reset, active low
	input  wire logic      cs_n_i,      // chip enable, active low
	input  wire dci_pins_t pins_i,      // command pins
	output int             cnt_o [9],   // commands seen, by kind
	output dci_pins_t      last_rw_o,   // last read or write
	output dci_pins_t      last_mode_o, // last mode write
	output int             viol_o       // protocol breaches
);
	int        cnt [9] = '{default: 0};
	int        viol    = 0;
	logic      cke_q   = 1'b0;
	logic [7:0] open_q = 8'h00;
	dci_pins_t rw_q;
	dci_pins_t mode_q;
	logic [2:0] s;
	int        k;

	assign cnt_o       = cnt;
	assign viol_o      = viol;
	assign last_rw_o   = rw_q;
	assign last_mode_o = mode_q;

	// a real device has no reset of its own, so commands are decoded only in run
	always @(posedge clk_mem_i) begin
		s = {pins_i.row_strobe_n, pins_i.column_strobe_n,
			pins_i.write_enable_n};
		k = 8;
		if (nrst_i && cs_n_i !== 1'b0)
			viol++;
		if (nrst_i && cke_q && !pins_i.mem_clock_enable && s == 3'b001) begin
			if (open_q != 8'h00)
				viol++;
			k = 7;
		end else if (nrst_i && cke_q && pins_i.mem_clock_enable) begin
			case (s)
				3'b011: begin
					if (open_q[pins_i.bank_addr_out])
						viol++;
					open_q[pins_i.bank_addr_out] = 1'b1;
					k = 0;
				end
				3'b010: begin
					if (pins_i.mem_addr_out[10])
						open_q = 8'h00;
					else
						open_q[pins_i.bank_addr_out] = 1'b0;
					k = pins_i.mem_addr_out[10] ? 1 : 2;
				end
				3'b000: begin
					if (open_q != 8'h00)
						viol++;
					mode_q = pins_i;
					k = 3;
				end
				3'b101, 3'b100: begin
					if (!open_q[pins_i.bank_addr_out])
						viol++;
					if (s[0] && pins_i.mem_addr_out[10])
						open_q[pins_i.bank_addr_out] = 1'b0;
					rw_q = pins_i;
					k = s[0] ? 4 : 5;
				end
				3'b001: begin
					if (open_q != 8'h00)
						viol++;
					k = 6;
				end
				default: k = 8;
			endcase
		end
		cnt[k]++;
		cke_q = pins_i.mem_clock_enable;
	end
endmodule // dci_sdram_model

// file: verif/ddr2_command_issue_test.sv
`timescale 1ns/10ps
module ddr2_command_issue_test;
	import dci_pkg::*;
	logic clk_sys_i = 1'b0, clk_mem_i = 1'b0, nrst_i = 1'b0;
	logic req_valid_i = 1'b0, req_write_i = 1'b0, req_autopre_i = 1'b0;
	dci_bank_t req_bank_i = 3'h0;
	dci_addr_t req_row_i = 14'h0000;
	logic [12:0] req_col_i = 13'h0000;
	dci_rate_t refresh_rate_i = 13'h0fff;
	logic [12:0] mode_reg_i = 13'h0a53, ext_mode_reg_i = 13'h0404;
	logic self_refresh_i = 1'b0, power_down_i = 1'b0;
	logic req_ready_o, req_done_o, init_done_o, low_power_o;
	logic chip_enable_n_o, mem_clock_enable_o, row_strobe_n_o;
	logic column_strobe_n_o, write_enable_n_o;
	dci_bank_t bank_addr_out_o;
	dci_addr_t mem_addr_out_o;
	dci_pins_t pins, last_rw, last_mode;
	int cnt [9];
	int viol, error_cnt = 0, comparisons = 0, cyc = 0, dones = 0;

	assign pins = {mem_clock_enable_o, row_strobe_n_o, column_strobe_n_o,
		write_enable_n_o, bank_addr_out_o, mem_addr_out_o};

	dci_cmd_issue uut (.clk_sys_i(clk_sys_i), .clk_mem_i(clk_mem_i),
		.nrst_i(nrst_i), .req_valid_i(req_valid_i),
		.req_ready_o(req_ready_o), .req_write_i(req_write_i),
		.req_autopre_i(req_autopre_i), .req_bank_i(req_bank_i),
		.req_row_i(req_row_i), .req_col_i(req_col_i),
		.req_done_o(req_done_o), .refresh_rate_i(refresh_rate_i),
		.mode_reg_i(mode_reg_i), .ext_mode_reg_i(ext_mode_reg_i),
		.self_refresh_i(self_refresh_i), .power_down_i(power_down_i),
		.init_done_o(init_done_o), .low_power_o(low_power_o),
		.chip_enable_n_o(chip_enable_n_o),
		.mem_clock_enable_o(mem_clock_enable_o),
		.row_strobe_n_o(row_strobe_n_o),
		.column_strobe_n_o(column_strobe_n_o),
		.write_enable_n_o(write_enable_n_o),
		.bank_addr_out_o(bank_addr_out_o), .mem_addr_out_o(mem_addr_out_o));

	dci_sdram_model mem (.clk_mem_i(clk_mem_i), .nrst_i(nrst_i),
		.cs_n_i(chip_enable_n_o), .pins_i(pins), .cnt_o(cnt),
		.last_rw_o(last_rw), .last_mode_o(last_mode), .viol_o(viol));

	// ----------------------------------------------------------------
	// clocks and hang guard
	// ----------------------------------------------------------------
	initial forever #50 clk_sys_i = ~clk_sys_i;
	// link clock offset so its edges never line up with the system's
	initial begin
		#7;
		forever #15 clk_mem_i = ~clk_mem_i;
	end
	// done pulses, read at the edge before the design moves them
	always @(posedge clk_sys_i) begin
		if (req_done_o === 1'b1)
			dones++;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic close_out();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one request; da and dp are the expected activates and single-bank precharges
	task automatic access(input logic w, ap, input dci_bank_t b,
		input dci_addr_t r, input logic [12:0] c, input int da, dp);
		int n, a, p, d;
		d = dones;
		n = cnt[4] + cnt[5];
		a = cnt[0];
		p = cnt[2];
		@(posedge clk_sys_i);
		req_valid_i <= 1'b1;
		req_write_i <= w;
		req_autopre_i <= ap;
		req_bank_i <= b;
		req_row_i <= r;
		req_col_i <= c;
		// ready is read only where it is settled, never on its edge
		@(negedge clk_sys_i);
		for (int i = 0; i < 500 && req_ready_o !== 1'b1; i++)
			@(negedge clk_sys_i);
		@(posedge clk_sys_i);
		req_valid_i <= 1'b0;
		for (int i = 0; i < 900 && cnt[4] + cnt[5] == n; i++)
			@(posedge clk_mem_i);
		chk(32'(cnt[4] + cnt[5]), 32'(n + 1), "one command");
		chk(32'(dones - d), 32'd1, "one done pulse");
		chk(32'(cnt[0] - a), 32'(da), "activate count");
		chk(32'(cnt[2] - p), 32'(dp), "single precharge");
		chk(32'(last_rw), 32'({1'b1, 1'b1, 1'b0, ~w, b, 1'b0, c[12:11],
			ap & ~w, c[9:0]}), "read or write pins");
	endtask

	task automatic t_init();
		for (int i = 0; i < 3000 && req_ready_o !== 1'b1; i++)
			@(negedge clk_sys_i);
		chk(32'(init_done_o), 32'd1, "init done");
		chk(32'(cnt[3]), 32'd2, "two mode writes");
		chk(32'(cnt[1] >= 3), 32'd1, "precharge all");
		chk(32'(last_mode), 32'({4'b1000, 3'h0, 1'b0, mode_reg_i}),
			"mode write pins");
	endtask

	task automatic t_pages();
		access(1'b0, 1'b0, 3'h2, 14'h0123, 13'h0045, 1, 0);
		access(1'b1, 1'b0, 3'h2, 14'h0123, 13'h1001, 0, 0);
		access(1'b0, 1'b0, 3'h2, 14'h0777, 13'h03ff, 1, 1);
		access(1'b0, 1'b1, 3'h5, 14'h3fff, 13'h0200, 1, 0);
		access(1'b1, 1'b1, 3'h5, 14'h3fff, 13'h0000, 1, 0);
	endtask

	task automatic t_low(input logic sr);
		int e;
		e = cnt[7];
		@(posedge clk_sys_i);
		self_refresh_i <= sr;
		power_down_i <= ~sr;
		for (int i = 0; i < 500 && low_power_o !== 1'b1; i++)
			@(negedge clk_sys_i);
		chk(32'(mem_clock_enable_o), 32'd0, "cke low");
		chk(32'(low_power_o), 32'd1, "in low power");
		chk(32'(cnt[7] - e), 32'(sr), "self refresh entry");
		@(posedge clk_sys_i);
		self_refresh_i <= 1'b0;
		power_down_i <= 1'b0;
		for (int i = 0; i < 900 && req_ready_o !== 1'b1; i++)
			@(negedge clk_sys_i);
		chk(32'(mem_clock_enable_o), 32'd1, "cke high");
	endtask

	task automatic t_refresh();
		int r, p;
		@(posedge clk_sys_i);
		refresh_rate_i <= 13'h0064;
		// the new rate loads only at the tick of the old count
		r = cnt[6];
		for (int i = 0; i < 4500 && cnt[6] == r; i++)
			@(posedge clk_sys_i);
		r = cnt[6];
		p = cnt[1];
		repeat (1000) @(posedge clk_sys_i);
		r = cnt[6] - r;
		chk(32'(r >= 8 && r <= 11), 32'd1, "refresh rate");
		chk(32'(cnt[1] - p >= r), 32'd1, "precharge first");
		access(1'b0, 1'b0, 3'h2, 14'h0777, 13'h0004, 1, 0);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		t_init();
		t_pages();
		t_low(1'b1);
		t_low(1'b0);
		t_refresh();
		chk(32'(cnt[3]), 32'd2, "no later mode write");
		chk(32'(viol), 32'd0, "protocol breaches");
		close_out();
	end
endmodule // ddr2_command_issue_test
